// file: design/logic_cell.sv
// Configurable logic cell: function generator, two storage elements,
// input selection, neighbour paths, edge links and one link point.
// Assumes configuration is loaded while cfg_mode_in is high, then held.
`timescale 1ns/1ps
`default_nettype none
module logic_cell (
    input  wire logic                               ref_clk_in,
    input  wire logic                               rst_n_in,
    // Configuration load port
    input  wire logic                               cfg_mode_in,
    input  wire logic                               cfg_we_in,
    input  wire logic [4:0]                         cfg_addr_in,
    input  wire logic                               cfg_data_in,
    input  wire logic [1:0]                         cfg_opt_in,
    input  wire logic [7:0]                         cfg_var_sel_in,
    input  wire logic [1:0]                         cfg_fourth_sel_in,
    input  wire logic [3:0]                         cfg_dsrc_in,
    input  wire logic [3:0]                         cfg_osrc_in,
    input  wire logic [9:0]                         cfg_net_sel_in,
    input  wire logic                               cfg_clear_en_in,
    input  wire logic                               cfg_hold_en_in,
    input  wire logic                               cfg_link_in,
    input  wire logic [2:0]                         cfg_link_kind_in,
    input  wire logic                               cfg_rpt_dir_in,
    input  wire logic [1:0]                         cfg_edge_in,
    // General routing segments adjacent to each input
    input  wire logic [4:0]                         seg_in,
    // Neighbour paths
    input  wire logic                               left_one_in,
    input  wire logic                               right_one_in,
    input  wire logic                               above_two_in,
    input  wire logic                               below_two_in,
    input  wire logic                               data_in,
    input  wire logic                               hold_enable_in,
    input  wire logic                               cell_clear_in,
    input  wire logic                               clk_en_in,
    // Link point ends and repeater ends
    input  wire logic                               link_a_in,
    input  wire logic                               link_b_in,
    input  wire logic                               rpt_a_in,
    input  wire logic                               rpt_b_in,
    input  wire logic                               pin_cell_in,
    output logic                                    blk_out_one_out,
    output logic                                    blk_out_two_out,
    output logic                                    lut_out_one_out,
    output logic                                    lut_out_two_out,
    output logic                                    reg_one_out,
    output logic                                    reg_two_out,
    output logic                                    link_a_out,
    output logic                                    link_a_oe_out,
    output logic                                    link_b_out,
    output logic                                    link_b_oe_out,
    output logic                                    rpt_a_out,
    output logic                                    rpt_a_oe_out,
    output logic                                    rpt_b_out,
    output logic                                    rpt_b_oe_out,
    output logic                                    pin_cell_out,
    output logic                                    pin_cell_oe_out,
    output logic                                    edge_extra_out
);
    import logic_cell_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        func_opt_e   opt;
        logic [7:0]  var_sel;
        logic [1:0]  fourth_sel;
        logic [3:0]  dsrc;
        logic [3:0]  osrc;
        logic [9:0]  net_sel;
        logic        clear_en;
        logic        hold_en;
        logic        link;
        logic [2:0]  link_kind;
        logic        rpt_dir;
        logic [1:0]  edge_cfg;
        logic [1:0]  regs;
        logic [1:0]  lut;
        logic [1:0]  blk;
        logic [1:0]  link_o;
        logic [1:0]  link_oe;
        logic [1:0]  rpt_o;
        logic [1:0]  rpt_oe;
        logic        pin_o;
        logic        pin_oe;
        logic        extra;
        logic        fifth_q;  // Fifth input aligned with the table read
    } cell_s;

    cell_s       st;
    cell_s       next_st;
    logic [4:0]  cin;
    logic [4:0]  addr_a;
    logic [4:0]  addr_b;
    logic        tab_a;
    logic        tab_b;
    logic [1:0]  lut_now;

    // Pick one variable from the shared pool
    function automatic logic pick_var(input logic [1:0] sel, input logic [4:0] c,
                                      input logic [1:0] q);
        unique case (sel)
            VAR_SECOND:  pick_var = c[1];
            VAR_THIRD:   pick_var = c[2];
            VAR_REG_ONE: pick_var = q[0];
            VAR_REG_TWO: pick_var = q[1];
        endcase
    endfunction

    // Select one cell input network; one-way, never driven back
    function automatic logic pick_net(input logic [1:0] sel, input logic seg,
                                      input logic nb);
        case (sel)
            NET_SEGMENT:   pick_net = seg;
            NET_NEIGHBOUR: pick_net = nb;
            default:       pick_net = 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // Input selection and table addressing
    // ****************************************************************
    // Input multiplexers with neighbour paths
    always_comb begin
        cin[0] = pick_net(st.net_sel[1:0], seg_in[0], above_two_in);
        cin[1] = pick_net(st.net_sel[3:2], seg_in[1], left_one_in);
        cin[2] = pick_net(st.net_sel[5:4], seg_in[2], right_one_in);
        cin[3] = pick_net(st.net_sel[7:6], seg_in[3], below_two_in);
        cin[4] = pick_net(st.net_sel[9:8], seg_in[4], 1'b0);
    end

    // Table addresses per option
    always_comb begin
        addr_a = '0;
        addr_b = '0;
        unique case (st.opt)
            opt_dual: begin
                addr_a = {1'b0, st.fourth_sel[0] ? cin[4] : cin[3],
                          pick_var(st.var_sel[3:2], cin, st.regs),
                          pick_var(st.var_sel[1:0], cin, st.regs), cin[0]};
                addr_b = {1'b1, st.fourth_sel[1] ? cin[4] : cin[3],
                          pick_var(st.var_sel[7:6], cin, st.regs),
                          pick_var(st.var_sel[5:4], cin, st.regs), cin[0]};
            end
            opt_single: begin
                addr_a = {cin[4], cin[3], pick_var(st.var_sel[3:2], cin, st.regs),
                          pick_var(st.var_sel[1:0], cin, st.regs), cin[0]};
                addr_b = addr_a;
            end
            opt_merged: begin
                addr_a = {1'b0, cin[3], pick_var(st.var_sel[3:2], cin, st.regs),
                          pick_var(st.var_sel[1:0], cin, st.regs), cin[0]};
                addr_b = {1'b1, cin[3], pick_var(st.var_sel[7:6], cin, st.regs),
                          pick_var(st.var_sel[5:4], cin, st.regs), cin[0]};
            end
            default: addr_a = '0;
        endcase
    end

    // Function table, 32 x 1
    cell_lut_mem u_lut (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .cfg_we_in   (cfg_mode_in & cfg_we_in),
        .cfg_addr_in (cfg_addr_in),
        .cfg_data_in (cfg_data_in),
        .addr_a_in   (addr_a),
        .addr_b_in   (addr_b),
        .data_a_out  (tab_a),
        .data_b_out  (tab_b)
    );

    // Combine table halves into the two results
    always_comb begin
        if (st.opt == opt_merged) begin
            lut_now = {2{st.fifth_q ? tab_b : tab_a}};
        end else if (st.opt == opt_single) begin
            lut_now = {2{tab_a}};
        end else begin
            lut_now = {tab_b, tab_a};
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.lut = lut_now;
        next_st.fifth_q = cin[4];
        // Configuration capture, static otherwise
        if (cfg_mode_in) begin
            next_st.opt        = func_opt_e'(cfg_opt_in);
            next_st.var_sel    = cfg_var_sel_in;
            next_st.fourth_sel = cfg_fourth_sel_in;
            next_st.dsrc       = cfg_dsrc_in;
            next_st.osrc       = cfg_osrc_in;
            next_st.net_sel    = cfg_net_sel_in;
            next_st.clear_en   = cfg_clear_en_in;
            next_st.hold_en    = cfg_hold_en_in;
            next_st.link       = cfg_link_in;
            next_st.link_kind  = cfg_link_kind_in;
            next_st.rpt_dir    = cfg_rpt_dir_in;
            next_st.edge_cfg   = cfg_edge_in;
            next_st.regs       = REG_RESET;
        end else if (st.clear_en && cell_clear_in) begin
            next_st.regs = REG_RESET;
        end else if (clk_en_in && !(st.hold_en && !hold_enable_in)) begin
            for (int i = 0; i < 2; i++) begin
                unique case (st.dsrc[2*i +: 2])
                    DSRC_LUT_ONE: next_st.regs[i] = lut_now[0];
                    DSRC_LUT_TWO: next_st.regs[i] = lut_now[1];
                    DSRC_DATA_IN: next_st.regs[i] = data_in;
                    default:      next_st.regs[i] = st.regs[i];
                endcase
            end
        end
        // Cell outputs
        for (int i = 0; i < 2; i++) begin
            unique case (st.osrc[2*i +: 2])
                OSRC_LUT_ONE: next_st.blk[i] = lut_now[0];
                OSRC_LUT_TWO: next_st.blk[i] = lut_now[1];
                OSRC_REG_ONE: next_st.blk[i] = st.regs[0];
                OSRC_REG_TWO: next_st.blk[i] = st.regs[1];
            endcase
        end
        // Link point: open unless closed by configuration
        next_st.link_oe = 2'b00;
        next_st.link_o  = 2'b00;
        if (!cfg_mode_in && st.link == LINK_CLOSED) begin
            unique case (st.link_kind)
                LINK_TWO_WAY: begin
                    next_st.link_oe = {link_b_in, link_a_in};
                    next_st.link_o  = {link_b_in, link_a_in};
                end
                LINK_H_TO_V, LINK_V_TO_H, LINK_TEE, LINK_CORNER: begin
                    next_st.link_oe = 2'b10;
                    next_st.link_o  = {link_b_in, 1'b0};
                end
                default: begin
                    next_st.link_oe = 2'b00;
                    next_st.link_o  = 2'b00;
                end
            endcase
        end
        // Repeater, direction fixed by configuration
        next_st.rpt_oe = cfg_mode_in ? 2'b00 : (st.rpt_dir ? 2'b01 : 2'b10);
        next_st.rpt_o  = st.rpt_dir ? {1'b0, rpt_a_in} : {rpt_b_in, 1'b0};
        // Edge link toward the pin cell
        next_st.pin_oe = !cfg_mode_in && st.edge_cfg[0];
        next_st.pin_o  = st.edge_cfg[0] ? st.blk[0] : 1'b0;
        next_st.extra  = st.edge_cfg[1] ? st.blk[1] : pin_cell_in;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign blk_out_one_out = st.blk[0];
    assign blk_out_two_out = st.blk[1];
    assign lut_out_one_out = st.lut[0];
    assign lut_out_two_out = st.lut[1];
    assign reg_one_out     = st.regs[0];
    assign reg_two_out     = st.regs[1];
    assign link_a_out      = st.link_o[1];
    assign link_a_oe_out   = st.link_oe[1];
    assign link_b_out      = st.link_o[0];
    assign link_b_oe_out   = st.link_oe[0];
    assign rpt_a_out       = st.rpt_o[1];
    assign rpt_a_oe_out    = st.rpt_oe[1];
    assign rpt_b_out       = st.rpt_o[0];
    assign rpt_b_oe_out    = st.rpt_oe[0];
    assign pin_cell_out    = st.pin_o;
    assign pin_cell_oe_out = st.pin_oe;
    assign edge_extra_out  = st.extra;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_same_results;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.opt != opt_dual) |=> (lut_out_one_out == lut_out_two_out);
    endproperty
    a_same_results: assert property (p_same_results)
        else $error("results differ outside dual option");

    property p_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (!cfg_mode_in && st.hold_en && !hold_enable_in && !(st.clear_en && cell_clear_in))
        |=> $stable(st.regs);
    endproperty
    a_hold: assert property (p_hold)
        else $error("storage changed while held");

    property p_clear;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.clear_en && cell_clear_in) || cfg_mode_in |=> (st.regs == 2'b00);
    endproperty
    a_clear: assert property (p_clear)
        else $error("storage not cleared");

    property p_link_open;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.link == LINK_OPEN) |=> (link_a_oe_out == 1'b0 && link_b_oe_out == 1'b0);
    endproperty
    a_link_open: assert property (p_link_open)
        else $error("open link point drives");

    property p_one_way;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.link_kind != LINK_TWO_WAY) |=> !link_b_oe_out;
    endproperty
    a_one_way: assert property (p_one_way)
        else $error("directional link drove backward");

    property p_static_cfg;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !cfg_mode_in |=> $stable(st.opt) && $stable(st.var_sel);
    endproperty
    a_static_cfg: assert property (p_static_cfg)
        else $error("configuration changed in operation");

    property p_rpt_one_dir;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> !(rpt_a_oe_out && rpt_b_oe_out);
    endproperty
    a_rpt_one_dir: assert property (p_rpt_one_dir)
        else $error("repeater drives both ways");

    property p_cfg_open;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        cfg_mode_in |=> !link_a_oe_out && !link_b_oe_out;
    endproperty
    a_cfg_open: assert property (p_cfg_open)
        else $error("link conducts while unprogrammed");
endmodule
`default_nettype wire

// file: design/logic_cell_pkg.sv
// Constants shared by the configurable logic cell and its lookup table.
// Assumes configuration bits are loaded by an outside loader and then held.
package logic_cell_pkg;

    // ****************************************************************
    // Function options
    // ****************************************************************
    typedef enum logic [1:0] {
        opt_dual   = 2'b00,
        opt_single = 2'b01,
        opt_merged = 2'b10
    } func_opt_e;

    // ****************************************************************
    // Source selects
    // ****************************************************************
    localparam int unsigned LUT_DEPTH   = 32;
    localparam int unsigned LUT_ABITS   = 5;
    localparam int unsigned HALF_DEPTH  = 16;
    localparam int unsigned DIR_COUNT   = 4;

    // Variable pool for the second and third table inputs
    localparam logic [1:0] VAR_SECOND  = 2'h0;
    localparam logic [1:0] VAR_THIRD   = 2'h1;
    localparam logic [1:0] VAR_REG_ONE = 2'h2;
    localparam logic [1:0] VAR_REG_TWO = 2'h3;

    // Storage data source
    localparam logic [1:0] DSRC_LUT_ONE = 2'h0;
    localparam logic [1:0] DSRC_LUT_TWO = 2'h1;
    localparam logic [1:0] DSRC_DATA_IN = 2'h2;

    // Cell output source
    localparam logic [1:0] OSRC_LUT_ONE = 2'h0;
    localparam logic [1:0] OSRC_LUT_TWO = 2'h1;
    localparam logic [1:0] OSRC_REG_ONE = 2'h2;
    localparam logic [1:0] OSRC_REG_TWO = 2'h3;

    // Link point states
    localparam logic LINK_OPEN   = 1'b0;
    localparam logic LINK_CLOSED = 1'b1;

    // Link point kinds
    localparam logic [2:0] LINK_TWO_WAY  = 3'h0;
    localparam logic [2:0] LINK_H_TO_V   = 3'h1;
    localparam logic [2:0] LINK_V_TO_H   = 3'h2;
    localparam logic [2:0] LINK_TEE      = 3'h3;
    localparam logic [2:0] LINK_CORNER   = 3'h4;

    // Input network choices per cell input
    localparam logic [1:0] NET_SEGMENT   = 2'h0;
    localparam logic [1:0] NET_NEIGHBOUR = 2'h1;
    localparam logic [1:0] NET_TIE_LOW   = 2'h2;

    // Reset values
    localparam logic [1:0] REG_RESET = 2'h0;

endpackage

// file: design/cell_lut_mem.sv
// Little 32 x 1 lookup memory for the logic cell.
// Assumes table contents are written only while configuring.
`timescale 1ns/1ps
`default_nettype none
module cell_lut_mem (
    input  wire logic                                  ref_clk_in,
    input  wire logic                                  rst_n_in,
    input  wire logic                                  cfg_we_in,
    input  wire logic [logic_cell_pkg::LUT_ABITS-1:0]  cfg_addr_in,
    input  wire logic                                  cfg_data_in,
    input  wire logic [logic_cell_pkg::LUT_ABITS-1:0]  addr_a_in,
    input  wire logic [logic_cell_pkg::LUT_ABITS-1:0]  addr_b_in,
    output logic                                       data_a_out,
    output logic                                       data_b_out
);
    import logic_cell_pkg::*;

    // ****************************************************************
    // Storage and registered reads
    // ****************************************************************
    logic [LUT_DEPTH-1:0] table_bits;

    // Table write, unprogrammed table holds zeros
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            table_bits <= '0;
            data_a_out <= 1'b0;
            data_b_out <= 1'b0;
        end else begin
            if (cfg_we_in) begin
                table_bits[cfg_addr_in] <= cfg_data_in;
            end
            data_a_out <= table_bits[addr_a_in];
            data_b_out <= table_bits[addr_b_in];
        end
    end
endmodule
`default_nettype wire

// file: sim/neighbour_model.sv
// Stand-in for the four neighbour cells and an edge pin cell.
// Assumes the bench sets levels just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module neighbour_model (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [4:0] level_in,
    output logic            below_two_out,
    output logic            left_one_out,
    output logic            right_one_out,
    output logic            above_two_out,
    output logic            pin_out
);
    // Neighbour outputs leave their own storage
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            {pin_out, above_two_out, right_one_out, left_one_out, below_two_out} <= 5'h00;
        end else begin
            {pin_out, above_two_out, right_one_out, left_one_out, below_two_out} <= level_in;
        end
    end
endmodule
`default_nettype wire

// file: sim/logic_cell_bench.sv
// Self-checking bench for the logic cell.
// Assumes the package and neighbour model compile first.
`timescale 1ns/1ps
`default_nettype none
module logic_cell_bench;
    import logic_cell_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic       clk = 1'b0, rst_n = 1'b0, cfg_mode = 1'b0, cfg_we = 1'b0, cfg_data = 1'b0;
    logic [4:0] cfg_addr = 5'h00, seg = 5'h00, nb = 5'h00;
    logic [1:0] opt = 2'h1, fsel = 2'h0;
    logic [3:0] dsrc = 4'h1, osrc = 4'h9;
    logic [9:0] net = 10'h000;
    logic       clr_en = 1'b0, hold_en = 1'b0, link = 1'b0, rpt_dir = 1'b1;
    logic       din = 1'b0, hold = 1'b1, clr = 1'b0, la_i = 1'b0, lb_i = 1'b0, ra_i = 1'b0;
    logic       l1, r1, a2, b2, pin, bo1, bo2, lo1, lo2, q1, q2;
    logic       la_oe, lb, lb_oe, ra_oe, rb, rb_oe;
    logic       la, ra, pin_o, pin_oe, extra, rb_i = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [1:0] edge_sel = 2'h0;
    int         n_mismatch = 0, cmp_count = 0;
    always #4 clk = ~clk;
    neighbour_model u_nb (.ref_clk_in(clk), .rst_n_in(rst_n), .level_in(nb),
        .below_two_out(b2), .left_one_out(l1), .right_one_out(r1), .above_two_out(a2),
        .pin_out(pin));
    logic_cell u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .cfg_mode_in(cfg_mode),
        .cfg_we_in(cfg_we), .cfg_addr_in(cfg_addr), .cfg_data_in(cfg_data), .cfg_opt_in(opt),
        .cfg_var_sel_in(8'h44), .cfg_fourth_sel_in(fsel), .cfg_dsrc_in(dsrc),
        .cfg_osrc_in(osrc), .cfg_net_sel_in(net), .cfg_clear_en_in(clr_en),
        .cfg_hold_en_in(hold_en), .cfg_link_in(link), .cfg_link_kind_in(kind),
        .cfg_rpt_dir_in(rpt_dir), .cfg_edge_in(edge_sel), .seg_in(seg), .left_one_in(l1),
        .right_one_in(r1), .above_two_in(a2), .below_two_in(b2), .data_in(din),
        .hold_enable_in(hold), .cell_clear_in(clr), .clk_en_in(1'b1), .link_a_in(la_i),
        .link_b_in(lb_i), .rpt_a_in(ra_i), .rpt_b_in(rb_i), .pin_cell_in(pin),
        .blk_out_one_out(bo1), .blk_out_two_out(bo2), .lut_out_one_out(lo1),
        .lut_out_two_out(lo2), .reg_one_out(q1), .reg_two_out(q2), .link_a_out(la),
        .link_a_oe_out(la_oe), .link_b_out(lb), .link_b_oe_out(lb_oe), .rpt_a_out(ra),
        .rpt_a_oe_out(ra_oe), .rpt_b_out(rb), .rpt_b_oe_out(rb_oe), .pin_cell_out(pin_o),
        .pin_cell_oe_out(pin_oe), .edge_extra_out(extra));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Loads a table holding the parity of its address
    task automatic cfg;
        cfg_mode = 1'b1;
        for (int i = 0; i < 32; i++) begin
            cfg_we = 1'b1;
            cfg_addr = i[4:0];
            cfg_data = ^cfg_addr;
            step(1);
        end
        cfg_we = 1'b0;
        cfg_mode = 1'b0;
        step(2);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        check("reg_one", q1, 1'b0);
        check("reg_two", q2, 1'b0);
        check("lut_one", lo1, 1'b0);
        check("link_b_oe", lb_oe, 1'b0);
        $display("test reset done");
    endtask
    // Five-input parity through the single and merged options, XOR of both half-table results in dual; lut, blk and reg_two checked outside dual
    task automatic t_func(input logic [1:0] o);
        opt = o;
        cfg;
        for (int i = 0; i < 32; i++) begin
            seg = i[4:0];
            step(6);
            if (o == opt_dual) begin
                check("lut_xor", lo1 ^ lo2, ~(seg[3] ^ seg[4]));
            end else begin
                check("lut_one", lo1, ^seg);
                check("lut_two", lo2, ^seg);
                check("blk_one", bo1, ^seg);
                check("blk_two", bo2, ^seg);
                check("reg_two", q2, ^seg);
            end
        end
        $display("test option %0d done", o);
    endtask
    task automatic t_store;
        hold_en = 1'b1;
        clr_en = 1'b1;
        dsrc = 4'ha;
        cfg;
        din = 1'b1;
        step(4);
        hold = 1'b0;
        din = 1'b0;
        step(4);
        check("held_one", q1, 1'b1);
        check("held_two", q2, 1'b1);
        hold = 1'b1;
        step(4);
        check("loaded", q1, 1'b0);
        din = 1'b1;
        clr = 1'b1;
        step(4);
        check("cleared", q2, 1'b0);
        clr = 1'b0;
        step(4);
        check("reloaded", q1, 1'b1);
        rst_n = 1'b0;
        step(2);
        check("chip_reset", q1, 1'b0);
        rst_n = 1'b1;
        step(1);
        dsrc = 4'h1;
        $display("test storage done");
    endtask
    task automatic t_paths;
        opt = opt_single;
        net = 10'h055;
        seg = 5'h0f;
        link = LINK_OPEN;
        cfg;
        for (int i = 0; i < 16; i++) begin
            nb = i[4:0];
            step(7);
            check("nb_lut", lo1, ^nb[3:0]);
        end
        la_i = 1'b1;
        lb_i = 1'b1;
        ra_i = 1'b1;
        step(4);
        check("open_a", la_oe, 1'b0);
        check("open_b", lb_oe, 1'b0);
        check("rpt_b", rb, 1'b1);
        check("rpt_b_oe", rb_oe, 1'b1);
        check("rpt_a_oe", ra_oe, 1'b0);
        link = LINK_CLOSED;
        cfg;
        lb_i = 1'b0;
        step(4);
        check("closed_b", lb, 1'b1);
        check("closed_oe", lb_oe, 1'b1);
        check("closed_a_oe", la_oe, 1'b0);
        // Only the fourth input from a neighbour, directional link, reversed repeater
        nb = 5'h18;
        net = 10'h040;
        kind = LINK_H_TO_V;
        rpt_dir = 1'b0;
        edge_sel = 2'h1;
        cfg;
        la_i = 1'b0;
        lb_i = 1'b1;
        rb_i = 1'b1;
        step(6);
        check("nb_fourth", lo1, ^{seg[2:0], nb[0]});
        check("dir_a", la, 1'b1);
        check("dir_a_oe", la_oe, 1'b1);
        check("dir_b_oe", lb_oe, 1'b0);
        check("rpt_a", ra, 1'b1);
        check("rpt_a_oe_rev", ra_oe, 1'b1);
        check("rpt_b_oe_rev", rb_oe, 1'b0);
        check("pin_oe", pin_oe, 1'b1);
        check("pin_out", pin_o, ^{seg[2:0], nb[0]});
        check("extra_in", extra, nb[4]);
        $display("test paths done");
    endtask
    initial begin
        step(16);
        rst_n = 1'b1;
        step(1);
        t_reset;
        t_func(opt_single);
        t_func(opt_merged);
        fsel = 2'h2;
        t_func(opt_dual);
        t_store;
        t_paths;
        results;
    end
    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        results;
    end
endmodule
`default_nettype wire
